// ==== inc/asdm_cfg.svh ====
// Purpose: constants of the axis speed and direction monitor
// Assumes: 25 MHz pclk, APB register access
// Notes:   byte offsets of one-word registers
// Contract
// R1 - each configured monitoring element reports its status as one enable output.
// R2 - limit enable drops when speed exceeds limit, unless tolerance absorbs it.
// R3 - limit enable returns automatically once speed is below limit minus hysteresis.
// R4 - with manual reset, limit enable waits for hysteresis return and reset input.
// R5 - twelve independent speed limits for the one axis.
// R6 - first overshoot starts tolerance evaluation with time, period and percentage.
// R7 - summed overshoot time within one tolerance period above tolerance time violates.
// R8 - new overshoot sooner than tolerance period after previous one violates.
// R9 - overshoot amplitude beyond limit plus percentage violates, both directions.
// R10 - limit enable is 1 while limit holds and 0 while exceeded.
// R11 - range enable drops outside min to max, returns inside with hysteresis.
// R12 - with manual reset, range enable waits for hysteresis return and reset input.
// R13 - two independent speed ranges for the one axis.
// R14 - range tolerance time, period and percentage apply to maximum and minimum.
// R15 - range enable is 1 inside the range and 0 outside.
// R16 - direction monitor stays active until opposite motion exceeds tolerance.
// R17 - each start rising edge restarts direction monitoring at current position.
// R18 - one direction element for positive, one for negative direction.
// R19 - configurer must not use direction monitoring with two proximity switches.
// R20 - configurer keeps direction tolerance below 24,900,000 increments.
// R21 - hysteresis applies only when an output switches back on.
// R22 - speed is increments per fixed sampling interval, checked every sample.
// R23 - after reset, enables low until valid speed and, for direction, start.
`ifndef ASDM_CFG_SVH
`define ASDM_CFG_SVH
`define ASDM_CLK_MHZ      25
`define ASDM_SAMPLE_US    1000
`define ASDM_PCT_DIV      100
`define ASDM_NLIM         12
`define ASDM_NRNG         2
`define ASDM_A_CTRL       8'h00
`define ASDM_A_STATUS     8'h04
`define ASDM_A_SPEED      8'h08
`define ASDM_A_POS        8'h0C
`define ASDM_A_TTIME      8'h10
`define ASDM_A_TPER       8'h14
`define ASDM_A_TPCT       8'h18
`define ASDM_A_HYST       8'h1C
`define ASDM_A_DTOL       8'h20
`define ASDM_A_ENA        8'h24
`define ASDM_A_LIM0       8'h40
`define ASDM_A_RNG0       8'h80
`define ASDM_B_LIM_MAN    0
`define ASDM_B_RNG_MAN    1
`endif

// ==== inc/asdm_pkg.sv ====
// Purpose: types of the axis speed and direction monitor
// Assumes: asdm_cfg.svh constants
// Notes:   one element record serves limits and ranges
package asdm_pkg;
	typedef struct packed {
		logic        en;
		logic        viol;
		logic        in_ovs;
		logic        seen;
		logic [15:0] acc;
		logic [15:0] gap;
	} asdm_elem_s;
	typedef struct packed {
		logic [7:0]  paddr;
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [31:0] pwdata;
	} asdm_apb_req_s;
endpackage : asdm_pkg

// ==== rtl/asdm_top.sv ====
// Purpose: single axis speed limit, speed range and direction monitor
// Assumes: increment step/up pins, start and reset pins, APB access
// Notes:   tolerance times and periods counted in speed samples
//
// The placing of the registers and the APB register port were decided locally.
`timescale 1ns/1ps
`include "asdm_cfg.svh"
module asdm_top
	import asdm_pkg::*;
#(
	parameter int SAMPLE_CYC = `ASDM_SAMPLE_US * `ASDM_CLK_MHZ
) (
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	input  wire asdm_apb_req_s        apb_req,
	output logic [31:0]               prdata,
	output logic                      pready,
	output logic                      pslverr,
	input  wire logic                 inc_step,
	input  wire logic                 inc_up,
	input  wire logic                 start_in,
	input  wire logic                 reset_in,
	output logic [`ASDM_NLIM-1:0]     lim_en,
	output logic [`ASDM_NRNG-1:0]     rng_en,
	output logic [1:0]                dir_en
);
	// ==================================================
	// state
	typedef struct packed {
		logic [2:0]                    step_s;
		logic [1:0]                    up_s;
		logic [2:0]                    start_s;
		logic [2:0]                    rst_s;
		logic                          rst_pend;
		logic [31:0]                   cnt;
		logic                          tick;
		logic signed [16:0]            win;
		logic [15:0]                   spd;
		logic                          valid;
		logic signed [31:0]            pos;
		logic [1:0]                    ctrl;
		logic [15:0]                   ena;
		logic [15:0]                   ttime;
		logic [15:0]                   tper;
		logic [7:0]                    tpct;
		logic [15:0]                   hyst;
		logic [31:0]                   dtol;
		logic [`ASDM_NLIM-1:0][15:0]   lim;
		logic [2*`ASDM_NRNG-1:0][15:0] rng;
		asdm_elem_s [`ASDM_NLIM-1:0]   le;
		asdm_elem_s [`ASDM_NRNG-1:0]   re;
		logic [1:0]                    dact;
		logic signed [1:0][31:0]       dref;
		logic [31:0]                   rdata;
		logic                          rerr;
	} asdm_state_s;

	asdm_state_s s_q;
	asdm_state_s s_d;

	localparam logic [31:0] SAMPLE_LAST = 32'(SAMPLE_CYC - 1);

	// ==================================================
	// functions
	function automatic logic [16:0] pct_of(input logic [15:0] v, input logic [7:0] p);
		logic [23:0] prod;
		prod = 24'(v) * 24'(p);
		return 17'(prod / 24'(`ASDM_PCT_DIV));
	endfunction : pct_of

	// one sample of tolerance evaluation for a limit or a range element
	function automatic asdm_elem_s elem_step(input asdm_elem_s e, input logic over, input logic hard,
			input logic back, input logic manual, input logic rst, input logic act,
			input logic [15:0] ttime, input logic [15:0] tper);
		asdm_elem_s n;
		logic       bad;
		n   = e;
		bad = 1'b0;
		if (over) begin
			if (!e.in_ovs && e.seen && e.gap < tper)
				bad = 1'b1; // [R8]
			if (e.acc != 16'hFFFF)
				n.acc = e.acc + 16'h0001;
			if (n.acc > ttime)
				bad = 1'b1; // [R7] [R6]
			if (hard)
				bad = 1'b1; // [R9]
			n.in_ovs = 1'b1;
			n.seen   = 1'b1;
			n.gap    = 16'h0000;
		end else begin
			n.in_ovs = 1'b0;
			if (e.gap != 16'hFFFF)
				n.gap = e.gap + 16'h0001;
			// a quiet full period starts a fresh accumulation window
			if (n.gap >= tper)
				n.acc = 16'h0000;
		end
		if (bad || !act)
			n.viol = act; // [R2]
		else if (e.viol && back && (!manual || rst))
			n.viol = 1'b0; // [R3] [R4] [R21]
		n.en = act && !n.viol; // [R10] [R23]
		return n;
	endfunction : elem_step

	// ==================================================
	// next state
	logic        wr_acc;
	logic        rd_set;
	logic        start_rise;
	logic        step_rise;
	logic [16:0] hyst17;
	logic [16:0] hi;
	logic [16:0] lo;
	logic [16:0] spd17;
	logic [7:0]  ra;
	// packed array elements select unsigned; these keep the reverse test signed
	logic signed [31:0] dref_k;
	logic signed [31:0] back_mv;

	assign wr_acc     = apb_req.psel && apb_req.penable && apb_req.pwrite;
	assign rd_set     = apb_req.psel && !apb_req.penable;
	assign start_rise = s_q.start_s[1] && !s_q.start_s[2];
	assign step_rise  = s_q.step_s[1] && !s_q.step_s[2];
	assign hyst17     = {1'b0, s_q.hyst};
	assign spd17      = {1'b0, s_q.spd};

	always_comb begin
		s_d     = s_q;
		hi      = 17'h00000;
		lo      = 17'h00000;
		ra      = 8'h00;
		dref_k  = '0;
		back_mv = '0;
		// two flops before any logic looks at a pin
		s_d.step_s  = {s_q.step_s[1:0], inc_step};
		s_d.up_s    = {s_q.up_s[0], inc_up};
		s_d.start_s = {s_q.start_s[1:0], start_in};
		s_d.rst_s   = {s_q.rst_s[1:0], reset_in};
		if (s_q.rst_s[1] && !s_q.rst_s[2])
			s_d.rst_pend = 1'b1;
		// position and sampling window
		if (step_rise) begin
			s_d.pos = s_q.up_s[1] ? s_q.pos + 32'sd1 : s_q.pos - 32'sd1;
			s_d.win = s_q.up_s[1] ? s_q.win + 17'sd1 : s_q.win - 17'sd1;
		end
		s_d.tick = 1'b0;
		if (s_q.cnt >= SAMPLE_LAST) begin
			s_d.cnt  = 32'h0000_0000;
			s_d.tick = 1'b1; // [R22]
			s_d.spd  = s_q.win[16] ? 16'(-s_q.win) : s_q.win[15:0];
			s_d.win  = step_rise ? (s_q.up_s[1] ? 17'sd1 : -17'sd1) : 17'sd0;
			s_d.valid = 1'b1;
		end else begin
			s_d.cnt = s_q.cnt + 32'h0000_0001;
		end
		// limit and range evaluation once per sample, on the fresh speed
		if (s_q.tick) begin
			for (int i = 0; i < `ASDM_NLIM; i++) begin
				hi = {1'b0, s_q.lim[i]} + pct_of(s_q.lim[i], s_q.tpct);
				s_d.le[i] = elem_step(s_q.le[i], spd17 > {1'b0, s_q.lim[i]}, spd17 > hi,
					spd17 + hyst17 <= {1'b0, s_q.lim[i]}, s_q.ctrl[`ASDM_B_LIM_MAN], s_q.rst_pend,
					s_q.ena[i] && s_q.valid, s_q.ttime, s_q.tper); // [R5] [R1]
			end
			for (int r = 0; r < `ASDM_NRNG; r++) begin
				hi = {1'b0, s_q.rng[2*r+1]} + pct_of(s_q.rng[2*r+1], s_q.tpct);
				lo = {1'b0, s_q.rng[2*r]} - pct_of(s_q.rng[2*r], s_q.tpct);
				if (pct_of(s_q.rng[2*r], s_q.tpct) > {1'b0, s_q.rng[2*r]})
					lo = 17'h00000;
				s_d.re[r] = elem_step(s_q.re[r],
					spd17 > {1'b0, s_q.rng[2*r+1]} || spd17 < {1'b0, s_q.rng[2*r]},
					spd17 > hi || spd17 < lo, // [R14]
					spd17 + hyst17 <= {1'b0, s_q.rng[2*r+1]} && spd17 >= {1'b0, s_q.rng[2*r]} + hyst17,
					s_q.ctrl[`ASDM_B_RNG_MAN], s_q.rst_pend,
					s_q.ena[`ASDM_NLIM+r] && s_q.valid, s_q.ttime, s_q.tper); // [R11] [R12] [R13] [R15]
			end
			// a reset edge landing on the sample cycle survives for the next one
			s_d.rst_pend = s_q.rst_s[1] && !s_q.rst_s[2];
		end
		// direction elements: 0 positive, 1 negative
		for (int k = 0; k < 2; k++) begin
			dref_k  = $signed(s_q.dref[k]);
			back_mv = (k == 0) ? dref_k - $signed(s_q.pos) : $signed(s_q.pos) - dref_k;
			if (!s_q.ena[`ASDM_NLIM+`ASDM_NRNG+k]) begin
				s_d.dact[k] = 1'b0;
			end else if (start_rise) begin
				s_d.dact[k] = 1'b1; // [R17]
				s_d.dref[k] = s_q.pos; // [R17]
			end else if (s_q.dact[k]) begin
				// reference follows motion in the permitted direction
				if (k == 0 ? $signed(s_q.pos) > dref_k : $signed(s_q.pos) < dref_k)
					s_d.dref[k] = s_q.pos;
				if (back_mv > $signed(s_q.dtol))
					s_d.dact[k] = 1'b0; // [R16] [R18]
			end
		end
		// APB: data latched in setup, answered in the zero-wait access
		if (rd_set) begin
			s_d.rdata = 32'h0000_0000;
			s_d.rerr  = 1'b0;
			ra        = apb_req.paddr;
			if (ra >= `ASDM_A_LIM0 && ra < `ASDM_A_LIM0 + 8'(4 * `ASDM_NLIM) && ra[1:0] == 2'b00)
				s_d.rdata = {16'h0000, s_q.lim[4'(ra[7:2] - `ASDM_A_LIM0 / 4)]};
			else if (ra >= `ASDM_A_RNG0 && ra < `ASDM_A_RNG0 + 8'(8 * `ASDM_NRNG) && ra[1:0] == 2'b00)
				s_d.rdata = {16'h0000, s_q.rng[2'(ra[7:2] - `ASDM_A_RNG0 / 4)]};
			else case (ra)
				`ASDM_A_CTRL:   s_d.rdata = {30'h0000_0000, s_q.ctrl};
				`ASDM_A_STATUS: s_d.rdata = {15'h0000, s_q.valid, dir_en, rng_en, lim_en};
				`ASDM_A_SPEED:  s_d.rdata = {16'h0000, s_q.spd};
				`ASDM_A_POS:    s_d.rdata = s_q.pos;
				`ASDM_A_TTIME:  s_d.rdata = {16'h0000, s_q.ttime};
				`ASDM_A_TPER:   s_d.rdata = {16'h0000, s_q.tper};
				`ASDM_A_TPCT:   s_d.rdata = {24'h00_0000, s_q.tpct};
				`ASDM_A_HYST:   s_d.rdata = {16'h0000, s_q.hyst};
				`ASDM_A_DTOL:   s_d.rdata = s_q.dtol;
				`ASDM_A_ENA:    s_d.rdata = {16'h0000, s_q.ena};
				default:        s_d.rerr  = 1'b1;
			endcase
		end
		if (wr_acc) begin
			ra = apb_req.paddr;
			if (ra >= `ASDM_A_LIM0 && ra < `ASDM_A_LIM0 + 8'(4 * `ASDM_NLIM) && ra[1:0] == 2'b00)
				s_d.lim[4'(ra[7:2] - `ASDM_A_LIM0 / 4)] = apb_req.pwdata[15:0];
			else if (ra >= `ASDM_A_RNG0 && ra < `ASDM_A_RNG0 + 8'(8 * `ASDM_NRNG) && ra[1:0] == 2'b00)
				s_d.rng[2'(ra[7:2] - `ASDM_A_RNG0 / 4)] = apb_req.pwdata[15:0];
			else case (ra)
				`ASDM_A_CTRL:  s_d.ctrl  = apb_req.pwdata[1:0];
				`ASDM_A_TTIME: s_d.ttime = apb_req.pwdata[15:0];
				`ASDM_A_TPER:  s_d.tper  = apb_req.pwdata[15:0];
				`ASDM_A_TPCT:  s_d.tpct  = apb_req.pwdata[7:0];
				`ASDM_A_HYST:  s_d.hyst  = apb_req.pwdata[15:0];
				`ASDM_A_DTOL:  s_d.dtol  = apb_req.pwdata; // [R20]
				`ASDM_A_ENA:   s_d.ena   = apb_req.pwdata[15:0]; // [R19]
				default:       s_d.ena   = s_q.ena;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	// ==================================================
	// outputs
	always_comb begin
		for (int i = 0; i < `ASDM_NLIM; i++)
			lim_en[i] = s_q.le[i].en;
		for (int r = 0; r < `ASDM_NRNG; r++)
			rng_en[r] = s_q.re[r].en;
	end
	assign dir_en  = s_q.dact;
	assign prdata  = s_q.rdata;
	assign pslverr = s_q.rerr && apb_req.psel && apb_req.penable;
	assign pready  = 1'b1;

	// ==================================================
	// assertions
	logic [16:0] hard0;
	assign hard0 = {1'b0, s_q.lim[0]} + pct_of(s_q.lim[0], s_q.tpct);

	property p_hard_overshoot;
		@(posedge pclk) disable iff (!presetn)
		s_q.tick && s_q.valid && s_q.ena[0] && spd17 > hard0 |=> !lim_en[0];
	endproperty
	a_hard_overshoot: assert property (p_hard_overshoot) else $error("amplitude overshoot kept limit on"); // [R9]

	property p_first_ovs_zero_tol;
		@(posedge pclk) disable iff (!presetn)
		s_q.tick && s_q.valid && s_q.ena[0] && s_q.ttime == 16'h0000
			&& spd17 > {1'b0, s_q.lim[0]} |=> !lim_en[0];
	endproperty
	a_first_ovs_zero_tol: assert property (p_first_ovs_zero_tol) else $error("untolerated overshoot ignored"); // [R2]

	property p_no_valid_no_en;
		@(posedge pclk) disable iff (!presetn)
		!s_q.valid |-> lim_en == '0 && rng_en == '0;
	endproperty
	a_no_valid_no_en: assert property (p_no_valid_no_en) else $error("enable before valid speed"); // [R23]

	property p_viol_low;
		@(posedge pclk) disable iff (!presetn)
		s_q.le[0].viol |-> !lim_en[0];
	endproperty
	a_viol_low: assert property (p_viol_low) else $error("limit enable high during violation"); // [R10]

	property p_manual_hold;
		@(posedge pclk) disable iff (!presetn)
		s_q.ctrl[`ASDM_B_LIM_MAN] && s_q.le[0].viol && !s_q.rst_pend && !(s_q.rst_s[1] && !s_q.rst_s[2])
			&& s_q.ena[0] |=> s_q.le[0].viol;
	endproperty
	a_manual_hold: assert property (p_manual_hold) else $error("manual reset bypassed"); // [R4]

	property p_range_out;
		@(posedge pclk) disable iff (!presetn)
		s_q.tick && s_q.valid && s_q.ena[`ASDM_NLIM] && s_q.ttime == 16'h0000
			&& spd17 > {1'b0, s_q.rng[1]} |=> !rng_en[0];
	endproperty
	a_range_out: assert property (p_range_out) else $error("range enable high outside range"); // [R15]

	sequence s_start_seen;
		start_rise && s_q.ena[`ASDM_NLIM+`ASDM_NRNG];
	endsequence
	property p_dir_start;
		@(posedge pclk) disable iff (!presetn)
		s_start_seen |=> dir_en[0] && s_q.dref[0] == $past(s_q.pos);
	endproperty
	a_dir_start: assert property (p_dir_start) else $error("start edge did not rearm direction"); // [R17]

	property p_dir_fault;
		@(posedge pclk) disable iff (!presetn)
		s_q.dact[0] && !start_rise && s_q.ena[`ASDM_NLIM+`ASDM_NRNG]
			&& $signed(s_q.dref[0]) - $signed(s_q.pos) > $signed(s_q.dtol) |=> !dir_en[0];
	endproperty
	a_dir_fault: assert property (p_dir_fault) else $error("reverse motion beyond tolerance ignored"); // [R16]

	property p_tick_spacing;
		@(posedge pclk) disable iff (!presetn)
		s_q.tick |=> !s_q.tick;
	endproperty
	a_tick_spacing: assert property (p_tick_spacing) else $error("sample ticks back to back"); // [R22]

	property p_range_under;
		@(posedge pclk) disable iff (!presetn)
		s_q.tick && s_q.valid && s_q.ena[`ASDM_NLIM] && s_q.ttime == 16'h0000
			&& spd17 < {1'b0, s_q.rng[0]} |=> !rng_en[0];
	endproperty
	a_range_under: assert property (p_range_under) else $error("range enable high below minimum"); // [R11]

	property p_auto_return;
		@(posedge pclk) disable iff (!presetn)
		s_q.tick && s_q.valid && s_q.ena[0] && !s_q.ctrl[`ASDM_B_LIM_MAN] && s_q.le[0].viol
			&& spd17 + hyst17 <= {1'b0, s_q.lim[0]} |=> lim_en[0];
	endproperty
	a_auto_return: assert property (p_auto_return) else $error("limit enable did not return"); // [R3]

	property p_hyst_hold;
		@(posedge pclk) disable iff (!presetn)
		s_q.le[0].viol && spd17 + hyst17 > {1'b0, s_q.lim[0]} |=> !lim_en[0];
	endproperty
	a_hyst_hold: assert property (p_hyst_hold) else $error("limit enable back on inside hysteresis"); // [R21]

	property p_gap_viol;
		@(posedge pclk) disable iff (!presetn)
		s_q.tick && s_q.valid && s_q.ena[0] && spd17 > {1'b0, s_q.lim[0]} && !s_q.le[0].in_ovs
			&& s_q.le[0].seen && s_q.le[0].gap < s_q.tper |=> !lim_en[0];
	endproperty
	a_gap_viol: assert property (p_gap_viol) else $error("overshoot inside tolerance period kept"); // [R8]

	property p_acc_viol;
		@(posedge pclk) disable iff (!presetn)
		s_q.tick && s_q.valid && s_q.ena[0] && spd17 > {1'b0, s_q.lim[0]} && s_q.le[0].acc >= s_q.ttime
			&& s_q.ttime != 16'hFFFF |=> !lim_en[0];
	endproperty
	a_acc_viol: assert property (p_acc_viol) else $error("tolerance time exceeded, limit kept on"); // [R7]

	property p_rng_manual_hold;
		@(posedge pclk) disable iff (!presetn)
		s_q.ctrl[`ASDM_B_RNG_MAN] && s_q.re[0].viol && !s_q.rst_pend && !(s_q.rst_s[1] && !s_q.rst_s[2])
			&& s_q.ena[`ASDM_NLIM] |=> s_q.re[0].viol;
	endproperty
	a_rng_manual_hold: assert property (p_rng_manual_hold) else $error("range manual reset bypassed"); // [R12]

	property p_dir_neg_fault;
		@(posedge pclk) disable iff (!presetn)
		s_q.dact[1] && !start_rise && s_q.ena[`ASDM_NLIM+`ASDM_NRNG+1]
			&& $signed(s_q.pos) - $signed(s_q.dref[1]) > $signed(s_q.dtol) |=> !dir_en[1];
	endproperty
	a_dir_neg_fault: assert property (p_dir_neg_fault) else $error("upward motion beyond tolerance ignored"); // [R18]

	property p_dir_needs_start;
		@(posedge pclk) disable iff (!presetn)
		!s_q.dact[0] && !start_rise |=> !dir_en[0];
	endproperty
	a_dir_needs_start: assert property (p_dir_needs_start) else $error("direction enable without start"); // [R23]

	property p_disabled_off;
		@(posedge pclk) disable iff (!presetn)
		s_q.tick && !s_q.ena[0] |=> !lim_en[0];
	endproperty
	a_disabled_off: assert property (p_disabled_off) else $error("disabled limit element reports on"); // [R1]

	property p_lim_idle;
		@(posedge pclk) disable iff (!presetn)
		!s_q.tick |=> $stable(lim_en) && $stable(rng_en);
	endproperty
	a_lim_idle: assert property (p_lim_idle) else $error("enable moved between samples"); // [R22]
endmodule : asdm_top

// ==== tb/asdm_enc.sv ====
// Purpose: encoder model on the far side of the increment pins
// Assumes: period of 4 or more pclk cycles, 0 stops the axis
// Notes:   step high two cycles per period, direction level with it
`timescale 1ns/1ps
module asdm_enc (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic [7:0] period,
	input  wire logic       up,
	output logic            inc_step,
	output logic            inc_up
);
	logic [7:0] cnt_q;

	// ==========================================
	// step generator
	// a true position source, so position-based monitors may be used
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q    <= 8'h00;
			inc_step <= 1'b0;
		end else if (period == 8'h00) begin
			cnt_q    <= 8'h00;
			inc_step <= 1'b0;
		end else begin
			// a shorter period must not let the count run on past its end
			cnt_q    <= (cnt_q >= period - 8'h01) ? 8'h00 : cnt_q + 8'h01;
			inc_step <= (cnt_q == period - 8'h03) || (cnt_q == period - 8'h02);
		end
	end
	assign inc_up = up;
endmodule : asdm_enc

// ==== tb/test_axis_speed_direction_monitor.sv ====
// Purpose: self-checking bench of the axis speed and direction monitor
// Assumes: short sample window of 50 cycles, APB with zero wait states
// Notes:   speeds 5, 10 and 2 divide the window exactly
`timescale 1ns/1ps
`include "asdm_cfg.svh"
module test_axis_speed_direction_monitor import asdm_pkg::*;;
	localparam int SC = 50;
	logic          pclk, presetn, start_in, reset_in, up, err;
	logic          pready, pslverr, inc_step, inc_up;
	logic [7:0]    period;
	logic [31:0]   prdata, rd;
	logic [11:0]   lim_en;
	logic [1:0]    rng_en, dir_en;
	logic [31:0]   lim [12];
	logic [31:0]   rmin [2];
	logic [31:0]   rmax [2];
	asdm_apb_req_s req;
	int            bad_count, total_checks;
	int            spd [3] = '{5, 10, 2};
	logic [7:0]    per [3] = '{8'h0A, 8'h05, 8'h19};
	logic [7:0]    hp [5]  = '{8'h19, 8'h0A, 8'h05, 8'h0A, 8'h19};

	asdm_top #(.SAMPLE_CYC(SC)) i_asdm_top (.pclk(pclk), .presetn(presetn), .apb_req(req),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .inc_step(inc_step),
		.inc_up(inc_up), .start_in(start_in), .reset_in(reset_in), .lim_en(lim_en),
		.rng_en(rng_en), .dir_en(dir_en));
	asdm_enc i_asdm_enc (.pclk(pclk), .presetn(presetn), .period(period), .up(up),
		.inc_step(inc_step), .inc_up(inc_up));

	// ==========================================
	// tasks
	task automatic test_done();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : test_done

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t %s", $time, m);
		end
	endtask : chk

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		req.psel    <= 1'b1;
		req.penable <= 1'b0;
		req.paddr   <= a;
		req.pwrite  <= w;
		req.pwdata  <= d;
		@(posedge pclk);
		req.penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			bad_count++;
			$display("CHECK FAILED t=%0t no pready", $time);
			test_done();
		end
		rd = prdata;
		err = pslverr;
		req.psel    <= 1'b0;
		req.penable <= 1'b0;
	endtask : apb

	// speed is settled by the period, then the wait runs cyc pclk cycles, whole samples only where cyc is a multiple of SC
	task automatic go(input logic [7:0] p, input int cyc);
		period <= p;
		repeat (cyc) @(posedge pclk);
	endtask : go

	task automatic pulse(input logic st);
		if (st) start_in <= 1'b1;
		else reset_in <= 1'b1;
		repeat (4) @(posedge pclk);
		start_in <= 1'b0;
		reset_in <= 1'b0;
		repeat (8) @(posedge pclk);
	endtask : pulse

	function automatic logic [13:0] expv(input int s);
		for (int i = 0; i < 12; i++) expv[i] = (s <= lim[i]);
		for (int r = 0; r < 2; r++) expv[12+r] = (s >= rmin[r]) && (s <= rmax[r]);
	endfunction : expv

	// ==========================================
	// clock and sequence
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end

	initial begin
		req = '0;
		presetn = 1'b0;
		start_in = 1'b0;
		reset_in = 1'b0;
		up = 1'b1;
		period = 8'h00;
		bad_count = 0;
		total_checks = 0;
		void'($urandom(10));
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk({16'h0, dir_en, rng_en, lim_en}, 32'h0, "enables after reset");
		apb(1'b0, `ASDM_A_ENA, 32'h0);
		chk(rd, 32'h0, "enable reg reset");
		apb(1'b0, 8'h28, 32'h0);
		chk({rd[30:0], err}, 32'h1, "unmapped read");
		apb(1'b1, `ASDM_A_SPEED, 32'hFFFF);
		apb(1'b0, `ASDM_A_SPEED, 32'h0);
		chk(rd, 32'h0, "read-only write");
		apb(1'b1, `ASDM_A_ENA, 32'h3FFF);
		for (int t = 0; t < 3; t++) begin
			for (int i = 0; i < 12; i++) begin
				lim[i] = $urandom_range(12, 0);
				apb(1'b1, `ASDM_A_LIM0 + 8'(4*i), lim[i]);
			end
			for (int r = 0; r < 2; r++) begin
				rmin[r] = $urandom_range(6, 0);
				rmax[r] = rmin[r] + $urandom_range(8, 0);
				apb(1'b1, `ASDM_A_RNG0 + 8'(8*r), rmin[r]);
				apb(1'b1, `ASDM_A_RNG0 + 8'(8*r+4), rmax[r]);
			end
			for (int k = 0; k < 3; k++) begin
				go(per[k], 3*SC);
				chk({18'h0, rng_en, lim_en}, {18'h0, expv(spd[k])}, "enables");
			end
		end
		apb(1'b0, `ASDM_A_STATUS, 32'h0);
		chk(rd & 32'h1FFFF, {15'h0, 3'b100, expv(2)}, "status");
		apb(1'b0, `ASDM_A_SPEED, 32'h0);
		chk(rd, 32'h2, "measured speed");
		apb(1'b1, `ASDM_A_HYST, 32'h4);
		apb(1'b1, `ASDM_A_LIM0, 32'h8);
		for (int k = 0; k < 5; k++) begin
			go(hp[k], 3*SC);
			chk(lim_en[0], 32'(5'h13 >> k) & 32'h1, "hysteresis");
		end
		apb(1'b1, `ASDM_A_HYST, 32'h0);
		apb(1'b1, `ASDM_A_CTRL, 32'h3);
		apb(1'b1, `ASDM_A_RNG0, 32'h3);
		apb(1'b1, `ASDM_A_RNG0 + 8'h04, 32'h8);
		go(8'h05, 3*SC);
		go(8'h0A, 3*SC);
		chk({rng_en[0], lim_en[0]}, 32'h0, "held until manual reset");
		pulse(1'b0);
		go(8'h0A, 2*SC);
		chk({rng_en[0], lim_en[0]}, 32'h3, "manual reset");
		apb(1'b1, `ASDM_A_CTRL, 32'h0);
		apb(1'b1, `ASDM_A_TTIME, 32'h3);
		apb(1'b1, `ASDM_A_TPCT, 32'h0A);
		go(8'h05, 3*SC);
		chk({rng_en[0], lim_en[0]}, 32'h0, "amplitude");
		go(8'h0A, 3*SC);
		apb(1'b1, `ASDM_A_TPCT, 32'h32);
		go(8'h05, 2*SC);
		chk({rng_en[0], lim_en[0]}, 32'h3, "tolerated");
		go(8'h05, 4*SC);
		chk({rng_en[0], lim_en[0]}, 32'h0, "tolerance time");
		go(8'h0A, 3*SC);
		apb(1'b1, `ASDM_A_TPER, 32'h14);
		go(8'h05, 3*SC);
		chk({rng_en[0], lim_en[0]}, 32'h0, "tolerance period");
		apb(1'b1, `ASDM_A_ENA, 32'hFFFF);
		apb(1'b1, `ASDM_A_DTOL, 32'h3);
		go(8'h00, SC);
		chk(dir_en, 32'h0, "direction before start");
		pulse(1'b1);
		chk(dir_en, 32'h3, "direction started");
		go(8'h0A, 105);
		go(8'h00, 10);
		chk(dir_en, 32'h1, "ten steps up");
		pulse(1'b1);
		chk(dir_en, 32'h3, "restart");
		up <= 1'b0;
		go(8'h0A, 25);
		go(8'h00, 10);
		chk(dir_en, 32'h3, "inside tolerance");
		go(8'h0A, 65);
		go(8'h00, 10);
		chk(dir_en, 32'h2, "eight steps down");
		test_done();
	end
endmodule : test_axis_speed_direction_monitor
